// file: src/mbs_pkg.sv
// Constants for the serial request interpreter.
// Assumes a 200 MHz core clock and a UART-style byte stream.
package mbs_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam logic [2:0] BAUD_SEL_9600 = 3'h0;
  localparam logic [2:0] BAUD_SEL_19200 = 3'h1;
  localparam logic [2:0] BAUD_SEL_38400 = 3'h2;
  localparam logic [2:0] BAUD_SEL_57600 = 3'h3;
  localparam logic [2:0] BAUD_SEL_115200 = 3'h4;
  // Rates; the bit period is derived from the clock in the interpreter
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned BAUD_57600 = 57600;
  localparam int unsigned BAUD_115200 = 115200;
  // Character: 8 data, no parity, 1 stop
  localparam logic [3:0] DATA_BITS = 4'h8;
  // Inter-frame gap in character times that ends a frame
  localparam logic [7:0] GAP_CHARS = 8'h04;
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_FORCE_COIL = 8'h05;
  // Protocol addresses (zero-based) for the spaces
  localparam logic [15:0] LE_LONG_BASE = 16'h0064;
  localparam logic [15:0] LE_FLT_BASE = 16'h00C8;
  localparam logic [15:0] BE_LONG_BASE = 16'h0258;
  localparam logic [15:0] BE_FLT_BASE = 16'h02BC;
  localparam logic [15:0] SPACE_SPAN = 16'h000E;
  localparam logic [15:0] COIL_RUN = 16'h0000;
  localparam logic [15:0] COIL_GRAND = 16'h0001;
  localparam logic [15:0] COIL_ALARM = 16'h0008;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [3:0] REQ_LEN = 4'h8;
  localparam logic [6:0] ADDR_MIN = 7'h01;
endpackage

// file: src/mbs_slave.sv
// Serial request interpreter: receives frames, answers 01/03/05.
// Assumes a transceiver outside; rx comes from a pin and is synchronised.
`timescale 1ns/1ps
`default_nettype none
module mbs_slave
  import mbs_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = CLK_HZ
)
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Configuration
  input wire logic [2:0] baud_sel,
  input wire logic [6:0] station_addr,
  // Measurement values, indexed by value slot 0..6
  input wire logic [31:0] long_val [7],
  input wire logic [31:0] flt_val [7],
  input wire logic [1:0] alarm_sp,
  // Serial line
  input wire logic rx_pin,
  output logic tx_pin,
  output logic tx_oe,
  // Totalizer clear pulses
  output logic clr_run_r,
  output logic clr_grand_r
);
  typedef enum {ST_IDLE, ST_RX, ST_EXEC, ST_TX} mbs_state_type;
  mbs_state_type st_r, st_nxt;
  logic s1_r, s2_r, rxb_r, rxb_nxt;
  logic [15:0] div, bcnt_r, bcnt_nxt;
  logic [3:0] bit_r, bit_nxt, n_r, n_nxt, tn_r, tn_nxt, ti_r, ti_nxt;
  logic [9:0] sh_r, sh_nxt;
  logic [7:0] gap_r, gap_nxt;
  logic [7:0] buf_r [8], buf_nxt [8];
  logic tx_r, tx_nxt, oe_r, oe_nxt, cr_nxt, cg_nxt;

  function automatic logic [15:0] crc8(input logic [15:0] c,
                                       input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; second stage is the only reader of the first
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else if (clk_en) begin
      s1_r <= rx_pin;
      s2_r <= s1_r;
    end
  end

  // Bit period from the selected rate, default 9600
  always_comb begin
    case (baud_sel)
      BAUD_SEL_19200: div = 16'(CLK_FREQ_HZ / BAUD_19200);
      BAUD_SEL_38400: div = 16'(CLK_FREQ_HZ / BAUD_38400);
      BAUD_SEL_57600: div = 16'(CLK_FREQ_HZ / BAUD_57600);
      BAUD_SEL_115200: div = 16'(CLK_FREQ_HZ / BAUD_115200);
      default: div = 16'(CLK_FREQ_HZ / BAUD_DEFAULT);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame engine: receive, check, build reply, transmit
  always_comb begin
    logic [15:0] ra, rv, ca, rc;
    logic [31:0] v;
    logic [7:0] rb [8];
    logic [3:0] k;
    st_nxt = st_r;
    bcnt_nxt = bcnt_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rxb_nxt = rxb_r;
    gap_nxt = gap_r;
    buf_nxt = buf_r;
    n_nxt = n_r;
    tn_nxt = tn_r;
    ti_nxt = ti_r;
    tx_nxt = tx_r;
    oe_nxt = oe_r;
    cr_nxt = 1'b0;
    cg_nxt = 1'b0;
    ra = {buf_r[2], buf_r[3]};
    rv = {buf_r[4], buf_r[5]};
    rc = {buf_r[7], buf_r[6]};
    v = 32'h0000_0000;
    rb = buf_r;
    k = 4'h0;
    ca = CRC_INIT;
    case (st_r)
      ST_IDLE, ST_RX: begin
        // A low line starts a byte at once, even mid gap count, so
        // back-to-back characters keep their mid-bit sampling point
        if (!rxb_r) begin
          if (!s2_r) begin
            rxb_nxt = 1'b1;
            bit_nxt = 4'h0;
            bcnt_nxt = {1'b0, div[15:1]};
          end else if (st_r == ST_RX && bcnt_r != 16'h0000) begin
            bcnt_nxt = bcnt_r - 16'h0001;
          end else if (st_r == ST_RX) begin
            bcnt_nxt = div - 16'h0001;
            gap_nxt = gap_r + 8'h01;
            if (gap_r == {GAP_CHARS[4:0], 3'h0} + GAP_CHARS) begin
              st_nxt = ST_EXEC;
            end
          end
        end else if (bcnt_r != 16'h0000) begin
          bcnt_nxt = bcnt_r - 16'h0001;
        end else begin
          bcnt_nxt = div - 16'h0001;
          sh_nxt = {s2_r, sh_r[9:1]};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == DATA_BITS + 4'h1) begin
            rxb_nxt = 1'b0;
            bit_nxt = 4'h0;
            bcnt_nxt = 16'h0000;
            gap_nxt = 8'h00;
            st_nxt = ST_RX;
            if (s2_r && n_r < REQ_LEN) begin
              buf_nxt[n_r[2:0]] = sh_r[9:2];
              n_nxt = n_r + 4'h1;
            end
          end
        end
      end
      ST_EXEC: begin
        for (int i = 0; i < 6; i++) ca = crc8(ca, buf_r[i]);
        st_nxt = ST_IDLE;
        n_nxt = 4'h0;
        if (n_r == REQ_LEN && ca == rc && station_addr >= ADDR_MIN &&
            buf_r[0] == {1'b0, station_addr}) begin
          case (buf_r[1])
            FC_READ_COILS: begin
              // Coils 9 and 10 land in bits 0 and 1
              rb[2] = 8'h01;
              rb[3] = {6'h00, alarm_sp};
              k = 4'h4;
            end
            FC_READ_HOLD: begin
              // One value per request; quantity is not honoured beyond 1
              rb[2] = 8'h02;
              for (int i = 0; i < 7; i++) begin
                if (ra == LE_LONG_BASE + 16'(2 * i) ||
                    ra == LE_LONG_BASE + 16'(2 * i + 1) ||
                    ra == BE_LONG_BASE + 16'(2 * i) ||
                    ra == BE_LONG_BASE + 16'(2 * i + 1)) v = long_val[i];
                if (ra == LE_FLT_BASE + 16'(2 * i) ||
                    ra == LE_FLT_BASE + 16'(2 * i + 1) ||
                    ra == BE_FLT_BASE + 16'(2 * i) ||
                    ra == BE_FLT_BASE + 16'(2 * i + 1)) v = flt_val[i];
              end
              // Odd address picks the second word of the pair
              if ((ra >= BE_LONG_BASE) ^ ra[0]) begin
                rb[3] = v[31:24];
                rb[4] = v[23:16];
              end else begin
                rb[3] = v[15:8];
                rb[4] = v[7:0];
              end
              k = 4'h5;
            end
            FC_FORCE_COIL: begin
              // Coils are pulses; a coil read returns alarm_sp whatever the address
              cr_nxt = (rv == COIL_ON) &&
                       (ra == COIL_RUN || ra == COIL_GRAND);
              cg_nxt = (rv == COIL_ON) && (ra == COIL_GRAND);
              k = 4'h6;
            end
            default: k = 4'h0;
          endcase
        end
        if (k != 4'h0) begin
          ca = CRC_INIT;
          for (int i = 0; i < 8; i++) if (4'(i) < k) ca = crc8(ca, rb[i]);
          rb[k[2:0]] = ca[7:0];
          rb[3'(k + 4'h1)] = ca[15:8];
          buf_nxt = rb;
          tn_nxt = k + 4'h2;
          ti_nxt = 4'h0;
          bit_nxt = 4'h0;
          bcnt_nxt = div - 16'h0001;
          sh_nxt = {1'b1, rb[0], 1'b0};
          oe_nxt = 1'b1;
          st_nxt = ST_TX;
        end
      end
      ST_TX: begin
        tx_nxt = sh_r[0];
        if (bcnt_r != 16'h0000) begin
          bcnt_nxt = bcnt_r - 16'h0001;
        end else begin
          bcnt_nxt = div - 16'h0001;
          sh_nxt = {1'b1, sh_r[9:1]};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == DATA_BITS + 4'h1) begin
            bit_nxt = 4'h0;
            ti_nxt = ti_r + 4'h1;
            sh_nxt = {1'b1, buf_r[3'(ti_r + 4'h1)], 1'b0};
            if (ti_r + 4'h1 == tn_r) begin
              // Release the bus so the master may talk again
              oe_nxt = 1'b0;
              tx_nxt = 1'b1;
              bcnt_nxt = 16'h0000;
              st_nxt = ST_IDLE;
            end
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      bcnt_r <= 16'h0000;
      bit_r <= 4'h0;
      sh_r <= 10'h3FF;
      rxb_r <= 1'b0;
      gap_r <= 8'h00;
      buf_r <= '{default: 8'h00};
      n_r <= 4'h0;
      tn_r <= 4'h0;
      ti_r <= 4'h0;
      tx_r <= 1'b1;
      oe_r <= 1'b0;
      clr_run_r <= 1'b0;
      clr_grand_r <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      bcnt_r <= bcnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rxb_r <= rxb_nxt;
      gap_r <= gap_nxt;
      buf_r <= buf_nxt;
      n_r <= n_nxt;
      tn_r <= tn_nxt;
      ti_r <= ti_nxt;
      tx_r <= tx_nxt;
      oe_r <= oe_nxt;
      clr_run_r <= cr_nxt;
      clr_grand_r <= cg_nxt;
    end
  end

  assign tx_pin = tx_r;
  assign tx_oe = oe_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence tx_end_s;
    (st_r == ST_TX) ##1 (st_r == ST_IDLE);
  endsequence
  grand_clears_run_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clr_grand_r |-> clr_run_r) else $error("grand clear without run");
  clear_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clr_run_r && clk_en |=> !clr_run_r) else $error("clear not a pulse");
  drive_only_tx_a: assert property (@(posedge core_clk) disable iff (!rstn)
    tx_oe |-> st_r == ST_TX || $past(st_r) == ST_TX)
    else $error("driving outside reply");
  release_a: assert property (@(posedge core_clk) disable iff (!rstn)
    tx_end_s |-> !oe_nxt) else $error("bus not released");
  idle_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !tx_oe |-> tx_pin) else $error("line not idle high");
  addr_match_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_r == ST_EXEC && buf_r[0] != {1'b0, station_addr}) |=> st_r == ST_IDLE)
    else $error("answered foreign address");
  fc_only_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_r == ST_EXEC && clk_en && buf_r[1] != FC_READ_COILS &&
     buf_r[1] != FC_READ_HOLD && buf_r[1] != FC_FORCE_COIL) |=> st_r != ST_TX)
    else $error("unsupported code answered");
  coil_force_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(clr_grand_r) |-> $past(buf_r[1]) == FC_FORCE_COIL)
    else $error("clear without force");
endmodule
`default_nettype wire

// file: test/mbs_master_model.sv
// Behavioural bus master that talks to the serial request interpreter.
// Assumes the bench calls its tasks; a released bus idles high.
`timescale 1ns/1ps
`default_nettype none
module mbs_master_model (
  // Clock
  input wire logic core_clk,
  // Slave driver side of the bus
  input wire logic tx_pin,
  input wire logic tx_oe,
  // Line into the slave receiver
  output logic rx_line
);
  // Matches the bench's scaled clock figure at the fastest rate
  int bit_cyc = 16;
  byte unsigned rsp[$];
  logic bus;

  // Fail-safe bias pulls a released bus to idle
  assign bus = tx_oe ? tx_pin : 1'b1;
  initial rx_line = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Frame check sum, reflected polynomial, all ones start
  function automatic logic [15:0] crc16(input byte unsigned b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // One bit cell, always changed just after a falling edge
  task automatic put_bit(input logic b);
    rx_line = b;
    repeat (bit_cyc) @(negedge core_clk);
  endtask

  // Whole request, check sum low byte first, then idle line
  task automatic send_req(input byte unsigned f[$]);
    logic [15:0] c;
    c = crc16(f);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    @(negedge core_clk);
    foreach (f[i]) begin
      put_bit(1'b0);
      for (int k = 0; k < 8; k++) begin
        put_bit(f[i][k]);
      end
      put_bit(1'b1);
    end
  endtask

  // Reply bytes sampled mid-bit until two characters of silence
  task automatic get_reply(input int first_wait);
    int w;
    logic [7:0] d;
    rsp.delete();
    w = first_wait;
    forever begin
      // Falling edges keep clear of the slave's register updates
      while (bus && w > 0) begin
        @(negedge core_clk);
        w--;
      end
      if (bus) break;
      repeat (bit_cyc / 2) @(negedge core_clk);
      for (int k = 0; k < 8; k++) begin
        repeat (bit_cyc) @(negedge core_clk);
        d[k] = bus;
      end
      repeat (bit_cyc) @(negedge core_clk);
      rsp.push_back(d);
      w = 20 * bit_cyc;
    end
  endtask
endmodule
`default_nettype wire

// file: test/mbs_slave_tb_top.sv
// Self-checking bench for the serial request interpreter.
// Assumes the master model drives the line at the fastest rate.
`timescale 1ns/1ps
`default_nettype none
module mbs_slave_tb_top;
  import mbs_pkg::*;
  typedef struct {
    logic [47:0] req;
    logic [47:0] rsp;
    int n;
    int run;
    int grand;
  } mbs_row_type;
  // Nominal clock figure given to the slave so a bit lasts 16 cycles
  localparam int unsigned BENCH_HZ = 1_843_200;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [6:0] station_addr = 7'h11;
  logic [31:0] lv [7];
  logic [31:0] fv [7];
  logic [1:0] alarm_sp = 2'b10;
  logic rx_pin, tx_pin, tx_oe, clr_run_r, clr_grand_r;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int run_cnt = 0;
  int grand_cnt = 0;
  mbs_row_type rows [7] = '{
    '{48'h1103_006A_0001, 48'h1103_0256_7800, 5, 0, 0},
    '{48'h1103_006B_0001, 48'h1103_0212_3400, 5, 0, 0},
    '{48'h1103_025E_0001, 48'h1103_0212_3400, 5, 0, 0},
    '{48'h1103_02BF_0001, 48'h1103_02BA_BE00, 5, 0, 0},
    '{48'h1101_0008_0002, 48'h1101_0102_0000, 4, 0, 0},
    '{48'h1105_0000_FF00, 48'h1105_0000_FF00, 6, 1, 0},
    '{48'h1105_0001_FF00, 48'h1105_0001_FF00, 6, 1, 1}
  };

  mbs_slave #(.CLK_FREQ_HZ(BENCH_HZ)) uut (.core_clk(core_clk),
    .rstn(rstn), .clk_en(1'b1),
    .baud_sel(BAUD_SEL_115200), .station_addr(station_addr),
    .long_val(lv), .flt_val(fv), .alarm_sp(alarm_sp), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .tx_oe(tx_oe), .clr_run_r(clr_run_r),
    .clr_grand_r(clr_grand_r));
  mbs_master_model m (.core_clk(core_clk), .tx_pin(tx_pin),
    .tx_oe(tx_oe), .rx_line(rx_pin));

  always #2.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  // Pulse counts and hang guard; nine transfers of about 220 bits
  // at 16 cycles a bit take some 32k cycles
  always @(posedge core_clk) begin
    cyc++;
    if (clr_run_r === 1'b1) run_cnt++;
    if (clr_grand_r === 1'b1) grand_cnt++;
    if (cyc == 80_000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Quantity of one keeps each holding register read to a single register
  task automatic run_req(input logic [47:0] req);
    byte unsigned f[$];
    for (int i = 0; i < 6; i++) f.push_back(req[47-8*i -: 8]);
    run_cnt = 0;
    grand_cnt = 0;
    m.send_req(f);
    m.get_reply(60 * m.bit_cyc);
  endtask

  // Reply payload, then its check sum low byte first
  task automatic check_rsp(input logic [47:0] exp, input int n);
    byte unsigned b[$];
    check(16'(m.rsp.size()), 16'(n == 0 ? 0 : n + 2), "reply length");
    if (n > 0 && m.rsp.size() == n + 2) begin
      for (int i = 0; i < n; i++) begin
        check({8'h00, m.rsp[i]}, {8'h00, exp[47-8*i -: 8]}, "byte");
        b.push_back(m.rsp[i]);
      end
      check({m.rsp[n+1], m.rsp[n]}, m.crc16(b), "check sum");
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 7; i++) begin
      lv[i] = 32'h0101_0000 * (i + 1);
      fv[i] = 32'h0000_0202 * (i + 1);
    end
    lv[3] = 32'h1234_5678;
    fv[1] = 32'hCAFE_BABE;
    repeat (10) @(negedge core_clk);
    check({15'h0, tx_oe}, 16'h0000, "driver during reset");
    check({15'h0, tx_pin}, 16'h0001, "idle during reset");
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      run_req(rows[i].req);
      check_rsp(rows[i].rsp, rows[i].n);
      check(16'(run_cnt), 16'(rows[i].run), "run clears");
      check(16'(grand_cnt), 16'(rows[i].grand), "grand clears");
      $display("row %0d done", i);
    end
    run_req(48'h1203_006A_0001);
    check_rsp(48'h0, 0);
    $display("foreign station test done");
    run_req(48'h1104_006A_0001);
    check_rsp(48'h0, 0);
    $display("unknown code test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
